// ===== common/bsfe_regs.svh
/*
  Timing counts and boot flow encodings for the boot strap and fatal error
  sideband block.
  Assumes it is included by bare name from the package and design files.
*/
// Operation
// R1: Self-test strap enables self test; undriven means on
// R2: Boot flow decoded from service, agent, socket straps
// R3: Service boot strap high: minimal config, then stall
// R4: Service boot resumes only after scratchpad go
// R5: Undriven service boot strap means disabled
// R6: Assert fatal line on unrecoverable machine check
// R7: Fatal line only pulled low, never driven high
// R8: External low on fatal line raises machine check
// R9: Fatal line ignored until power good asserted
// R10: Machine check event holds line sixteen reference cycles
// R11: Internal fault holds line until reset
// R12: Reference clock 100 MHz; line counts use it
// R13: Straps captured once at reset release
`ifndef BSFE_REGS_SVH
`define BSFE_REGS_SVH

// Reference clock figures and block clock frequency
`define BSFE_REF_CLK_MHZ      100
`define BSFE_MCLK_MHZ         50
`define BSFE_MCE_REF_CYCLES   16
// Hold time in ns, then cycles of the 50 MHz clock (rounded up)
`define BSFE_MCE_HOLD_NS      \
  ((`BSFE_MCE_REF_CYCLES * 1000) / `BSFE_REF_CLK_MHZ)
`define BSFE_MCE_HOLD_CYC     \
  (((`BSFE_MCE_HOLD_NS * `BSFE_MCLK_MHZ) + 999) / 1000)

// Boot flow encodings
`define BSFE_FLOW_SERVICE     2'h0
`define BSFE_FLOW_LOCAL       2'h1
`define BSFE_FLOW_LINK_BOOT   2'h2
`define BSFE_FLOW_LINK_INIT   2'h3

`endif

// ===== common/bsfe_pkg.sv
/*
  Types shared by the boot strap and fatal error sideband block.
  Assumes bsfe_regs.svh is on the include path.
*/
`default_nettype none
package bsfe_pkg;
  `include "bsfe_regs.svh"

  typedef struct packed {
    logic       selftest;
    logic       service_boot;
    logic       firmware_agent;
    logic [1:0] socket_number;
  } bsfe_straps_t;

  typedef enum logic [1:0] {
    BSFE_FLOW_SERVICE_E,
    BSFE_FLOW_LOCAL_E,
    BSFE_FLOW_LINK_BOOT_E,
    BSFE_FLOW_LINK_INIT_E
  } bsfe_flow_t;
endpackage
`default_nettype wire

// ===== logic/bsfe_sync.sv
/*
  Two flip-flop synchroniser for a bus of asynchronous levels.
  Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bsfe_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

// ===== logic/bsfe_sideband.sv
/*
  Boot strap capture, service boot handshake and the shared fatal
  error line of one processor.
  Assumes straps and the fatal line are asynchronous pins, resolved
  with their on-die pulls by the surroundings, and that go and error
  events come from logic on i_mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bsfe_regs.svh"
module bsfe_sideband
  import bsfe_pkg::*;
#(
  parameter int MCE_HOLD_CYC = `BSFE_MCE_HOLD_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_selftest_strap,
  input  wire logic       i_service_boot_strap,
  input  wire logic       i_firmware_agent_strap,
  input  wire logic [1:0] i_socket_number_strap,
  input  wire logic       i_scratchpad_go,
  input  wire logic       i_power_good_in,
  input  wire logic       i_machine_check_event,
  input  wire logic       i_internal_fault_event,
  input  wire logic       i_fatal_error_n_in,
  output logic            o_fatal_error_n_out,
  output logic            o_fatal_error_n_oe,
  output logic            o_selftest_run,
  output bsfe_flow_t      o_boot_flow,
  output logic            o_boot_stalled,
  output logic            o_boot_resume,
  output logic            o_machine_check_exc
);
  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  logic [5:0] pins_async;
  logic [5:0] pins_sync;
  bsfe_straps_t straps_sync;
  logic pgood_sync;
  logic fatal_in_sync;

  assign pins_async = {i_selftest_strap, i_service_boot_strap,
                       i_firmware_agent_strap, i_socket_number_strap,
                       i_power_good_in};

  bsfe_sync #(
    .WIDTH   (6),
    .RST_VAL (6'h20)
  ) u_strap_sync (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_async (pins_async),
    .o_sync  (pins_sync)
  );

  bsfe_sync #(
    .WIDTH   (1),
    .RST_VAL (1'h1)
  ) u_fatal_sync (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_async (i_fatal_error_n_in),
    .o_sync  (fatal_in_sync)
  );

  assign straps_sync = bsfe_straps_t'(pins_sync[5:1]);
  assign pgood_sync  = pins_sync[0];

  //--------------------------------------------------------------------
  // Strap capture after reset release
  //--------------------------------------------------------------------
  // Waits for the synchronisers to refill before taking the straps
  logic [1:0]   settle_q;
  logic         captured_q;
  bsfe_straps_t straps_q;

  function automatic bsfe_flow_t decode_flow(input bsfe_straps_t s);
    if (s.service_boot)
      decode_flow = BSFE_FLOW_SERVICE_E;               // [R2]
    else if (s.firmware_agent && s.socket_number == 2'h0)
      decode_flow = BSFE_FLOW_LOCAL_E;                 // [R2] [R5]
    else if (s.firmware_agent)
      decode_flow = BSFE_FLOW_LINK_BOOT_E;             // [R2]
    else
      decode_flow = BSFE_FLOW_LINK_INIT_E;             // [R2]
  endfunction

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      settle_q   <= 2'h0;
      captured_q <= 1'b0;
      straps_q   <= '0;
    end else if (!captured_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == 2'h2) begin
        captured_q <= 1'b1;                            // [R13]
        straps_q   <= straps_sync;                     // [R13]
      end
    end
  end

  assign o_selftest_run = captured_q && straps_q.selftest;   // [R1]

  always_ff @(posedge i_mclk) begin
    if (!i_rstn)
      o_boot_flow <= BSFE_FLOW_LOCAL_E;
    else if (!captured_q && settle_q == 2'h2)
      o_boot_flow <= decode_flow(straps_sync);         // [R2]
  end

  //--------------------------------------------------------------------
  // Boot sequencing
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {
    BOOT_CAPTURE,
    BOOT_MINIMAL,
    BOOT_WAIT_GO,
    BOOT_RUN
  } bsfe_boot_state_t;

  bsfe_boot_state_t boot_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      boot_q <= BOOT_CAPTURE;
    end else begin
      case (boot_q)
        BOOT_CAPTURE: begin
          if (captured_q) begin
            if (straps_q.service_boot)
              boot_q <= BOOT_MINIMAL;                  // [R3]
            else
              boot_q <= BOOT_RUN;                      // [R5]
          end
        end
        BOOT_MINIMAL: begin
          boot_q <= BOOT_WAIT_GO;                      // [R3]
        end
        BOOT_WAIT_GO: begin
          if (i_scratchpad_go)
            boot_q <= BOOT_RUN;                        // [R4]
        end
        default: begin
          boot_q <= BOOT_RUN;
        end
      endcase
    end
  end

  assign o_boot_stalled = (boot_q == BOOT_WAIT_GO);    // [R3]
  assign o_boot_resume  = (boot_q == BOOT_RUN);        // [R4]

  //--------------------------------------------------------------------
  // Fatal error line drive
  //--------------------------------------------------------------------
  localparam logic [4:0] HOLD_CYC = 5'(MCE_HOLD_CYC);
  logic [4:0] hold_q;
  logic       fault_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn)
      hold_q <= 5'h00;
    else if (i_machine_check_event)
      hold_q <= HOLD_CYC;                              // [R6] [R10]
    else if (hold_q != 5'h00)
      hold_q <= hold_q - 5'h01;                        // [R10]
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn)
      fault_q <= 1'b0;                                 // [R11]
    else if (i_internal_fault_event)
      fault_q <= 1'b1;                                 // [R6] [R11]
  end

  // Open drain: output data always low, only the enable moves
  assign o_fatal_error_n_out = 1'b0;                   // [R7]
  assign o_fatal_error_n_oe  = fault_q || (hold_q != 5'h00);   // [R7]

  //--------------------------------------------------------------------
  // Fatal error line receive
  //--------------------------------------------------------------------
  // Own drive is excluded so a local assertion does not echo back; the
  // mask trails the drive by the synchroniser depth to cover the release
  logic [1:0] own_drive_q;
  logic       own_drive_mask;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn)
      own_drive_q <= 2'h0;
    else
      own_drive_q <= {own_drive_q[0], o_fatal_error_n_oe};
  end

  assign own_drive_mask = o_fatal_error_n_oe || (own_drive_q != 2'h0);

  always_ff @(posedge i_mclk) begin
    if (!i_rstn)
      o_machine_check_exc <= 1'b0;
    else
      o_machine_check_exc <= pgood_sync && !fatal_in_sync
                             && !own_drive_mask;       // [R8] [R9]
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  property p_mce_hold;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_machine_check_event && !i_internal_fault_event && !fault_q)
      ##1 (!i_machine_check_event && !i_internal_fault_event) [*8]
      |=> !o_fatal_error_n_oe;
  endproperty
  a_mce_hold: assert property (p_mce_hold)  // [R10]
    else $error("fatal line not released after machine check hold");

  property p_mce_on;
    @(posedge i_mclk) disable iff (!i_rstn)
    i_machine_check_event |=> o_fatal_error_n_oe [*8];
  endproperty
  a_mce_on: assert property (p_mce_on)  // [R6]
    else $error("fatal line not held after machine check");

  property p_fault_sticky;
    @(posedge i_mclk) disable iff (!i_rstn)
    i_internal_fault_event |=> o_fatal_error_n_oe [*8];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)  // [R11]
    else $error("fatal line released after internal fault");

  property p_never_high;
    @(posedge i_mclk) disable iff (!i_rstn)
    o_fatal_error_n_out == 1'b0;
  endproperty
  a_never_high: assert property (p_never_high)  // [R7]
    else $error("fatal line driven high");

  property p_pgood_gate;
    @(posedge i_mclk) disable iff (!i_rstn)
    !pgood_sync |=> !o_machine_check_exc;
  endproperty
  a_pgood_gate: assert property (p_pgood_gate)  // [R9]
    else $error("machine check taken before power good");

  property p_ext_mce;
    @(posedge i_mclk) disable iff (!i_rstn)
    (pgood_sync && !fatal_in_sync && !own_drive_mask)
      |=> o_machine_check_exc;
  endproperty
  a_ext_mce: assert property (p_ext_mce)  // [R8]
    else $error("external fatal assertion not taken");

  property p_wait_go;
    @(posedge i_mclk) disable iff (!i_rstn)
    (boot_q == BOOT_WAIT_GO && !i_scratchpad_go) |=> !o_boot_resume;
  endproperty
  a_wait_go: assert property (p_wait_go)  // [R4]
    else $error("boot resumed without go");

  property p_service_stall;
    @(posedge i_mclk) disable iff (!i_rstn)
    $rose(captured_q) && straps_q.service_boot |-> ##2 o_boot_stalled;
  endproperty
  a_service_stall: assert property (p_service_stall)  // [R3]
    else $error("service boot did not stall");

  property p_local_run;
    @(posedge i_mclk) disable iff (!i_rstn)
    $rose(captured_q) && !straps_q.service_boot |=> o_boot_resume;
  endproperty
  a_local_run: assert property (p_local_run)  // [R5]
    else $error("local boot did not proceed");

  property p_straps_stable;
    @(posedge i_mclk) disable iff (!i_rstn)
    captured_q |=> $stable(straps_q) && $stable(o_boot_flow);
  endproperty
  a_straps_stable: assert property (p_straps_stable)  // [R13]
    else $error("captured straps changed");

  property p_selftest;
    @(posedge i_mclk) disable iff (!i_rstn)
    captured_q |-> o_selftest_run == straps_q.selftest;
  endproperty
  a_selftest: assert property (p_selftest)  // [R1]
    else $error("self test does not follow strap");

  c_go: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    o_boot_stalled ##1 o_boot_resume);
  c_mce: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    $fell(o_fatal_error_n_oe));
  c_ext: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_machine_check_exc));
endmodule
`default_nettype wire

// ===== testbench/bsfe_platform_model.sv
/*
  Platform side of the sideband block: self-test and service boot strap pins with their on-die
  pulls and the shared fatal line with its pull-up and peer pulls.
  Assumes the design's open-drain enable and bench drive requests.
*/
`timescale 1ns/1ps
`default_nettype none
module bsfe_platform_model (
  input  wire logic i_dut_pull,
  input  wire logic i_dut_data,
  input  wire logic i_peer_pull,
  input  wire logic i_selftest_drv,
  input  wire logic i_selftest_val,
  input  wire logic i_service_drv,
  input  wire logic i_service_val,
  output logic      o_fatal_error_n,
  output logic      o_selftest_strap,
  output logic      o_service_boot_strap
);
  // ----------------------------------------
  // Wired line: parties only pull low
  // ----------------------------------------
  // A high level from the device does not pull, so the line stays up
  assign o_fatal_error_n = !((i_dut_pull & !i_dut_data) | i_peer_pull);
  // ----------------------------------------
  // Strap pins resolved with on-die pulls
  // ----------------------------------------
  assign o_selftest_strap = i_selftest_drv ? i_selftest_val : 1'h1;
  assign o_service_boot_strap = i_service_drv & i_service_val;
endmodule
`default_nettype wire

// ===== testbench/tb.sv
/*
  Self-checking bench for the sideband block: strap capture, service
  boot handshake and the shared fatal line.
  Assumes the platform model resolves pins and pulls.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bsfe_regs.svh"
module tb;
  import bsfe_pkg::*;
  localparam int MCLK_NS = 20;
  localparam int REF_NS  = 1000 / `BSFE_REF_CLK_MHZ;
  localparam int HOLD    = `BSFE_MCE_REF_CYCLES * REF_NS / MCLK_NS;
  logic        mclk, rstn, st_drv, st_val, sv_drv, sv_val, agent, go;
  logic        pgood, mce, ifault, peer, line_n, st_pin, sv_pin;
  logic        f_out, f_oe, st_run, stall, resume, exc, svc;
  logic [1:0]  sock;
  logic [6:0]  r;
  logic [16:0] lfsr;
  bsfe_flow_t  flow, e_flow;
  int          num_errors, checks_done, n;
  logic [6:0]  corner [5] = '{7'h00, 7'h19, 7'h05, 7'h21, 7'h10};

  bsfe_sideband i_bsfe_sideband (
    .i_mclk(mclk), .i_rstn(rstn), .i_selftest_strap(st_pin),
    .i_service_boot_strap(sv_pin), .i_firmware_agent_strap(agent),
    .i_socket_number_strap(sock), .i_scratchpad_go(go),
    .i_power_good_in(pgood), .i_machine_check_event(mce),
    .i_internal_fault_event(ifault), .i_fatal_error_n_in(line_n),
    .o_fatal_error_n_out(f_out), .o_fatal_error_n_oe(f_oe),
    .o_selftest_run(st_run), .o_boot_flow(flow),
    .o_boot_stalled(stall), .o_boot_resume(resume),
    .o_machine_check_exc(exc));
  bsfe_platform_model i_bsfe_platform_model (
    .i_dut_pull(f_oe), .i_dut_data(f_out), .i_peer_pull(peer),
    .i_selftest_drv(st_drv),
    .i_selftest_val(st_val), .i_service_drv(sv_drv),
    .i_service_val(sv_val), .o_fatal_error_n(line_n),
    .o_selftest_strap(st_pin), .o_service_boot_strap(sv_pin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [16:0] lfsr_next(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  function automatic bsfe_flow_t exp_flow(input logic s, input logic a,
                                          input logic [1:0] k);
    if (s) return BSFE_FLOW_SERVICE_E;
    if (a && k == 2'h0) return BSFE_FLOW_LOCAL_E;
    if (a) return BSFE_FLOW_LINK_BOOT_E;
    return BSFE_FLOW_LINK_INIT_E;
  endfunction
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Boots with one strap set, then for service boot exercises the go handshake
  task automatic boot(input logic [6:0] s);
    logic e_st;
    {sock, sv_drv, sv_val, st_drv, st_val, agent} = s;
    svc = sv_drv & sv_val;
    e_st = st_drv ? st_val : 1'h1;
    e_flow = exp_flow(svc, agent, sock);
    rstn = 1'h0;
    tick(6);
    rstn = 1'h1;
    tick(6);
    check(st_run, e_st);
    check(flow, e_flow);
    {sock, sv_drv, sv_val, st_drv, st_val, agent} = ~s;
    tick(3);
    check(st_run, e_st);
    check(flow, e_flow);
    check(stall, svc);
    check(resume, !svc);
    if (svc) begin
      tick(4);
      check(resume, 1'h0);
      go = 1'h1;
      tick(1);
      go = 1'h0;
      n = 0;
      while (!resume && n < 4) begin
        tick(1);
        n++;
      end
      check(resume, 1'h1);
      check(stall, 1'h0);
    end
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #1000000;
    num_errors++;
    finish_test();
  end
  initial begin
    {rstn, st_drv, st_val, sv_drv, sv_val, agent, go} = '0;
    {pgood, mce, ifault, peer, sock} = '0;
    num_errors = 0;
    checks_done = 0;
    lfsr = 17'h18178;
    for (int i = 0; i < 12; i++) begin
      r = (i < 5) ? corner[i] : lfsr[6:0];
      lfsr = lfsr_next(lfsr);
      boot(r);
    end
    peer = 1'h1;
    tick(6);
    check(exc, 1'h0);
    peer = 1'h0;
    pgood = 1'h1;
    tick(3);
    mce = 1'h1;
    tick(1);
    mce = 1'h0;
    check(f_oe, 1'h1);
    check(f_out, 1'h0);
    n = 0;
    repeat (HOLD + 4) begin
      n += f_oe;
      check(exc, 1'h0);
      tick(1);
    end
    check(4'(n), 4'(HOLD));
    check(exc, 1'h0);
    peer = 1'h1;
    n = 0;
    while (!exc && n < 6) begin
      tick(1);
      n++;
    end
    check(exc, 1'h1);
    peer = 1'h0;
    tick(5);
    check(exc, 1'h0);
    ifault = 1'h1;
    tick(1);
    ifault = 1'h0;
    tick(40);
    check(f_oe, 1'h1);
    check(line_n, 1'h0);
    rstn = 1'h0;
    tick(6);
    check(f_oe, 1'h0);
    rstn = 1'h1;
    tick(2);
    finish_test();
  end
endmodule
`default_nettype wire
